//--- verilog/sdc_sdram_core.sv
// two-bank synchronous dram core: command decode, banks, bursts, apb status
// assumes the controller runs on mclk; only cke is asynchronous
//
// Functional notes
// - activate latches row from address bits 0-8
// - read/write latches column from bits 0-7
// - precharge one bank or both by mode bit
// - auto precharge bank after burst ends
// - mode set loads all ten address bits
// - bank select bit picks bank 0 or 1
// - command from row, column, write strobes
// - clock enable low ignores the edge
// - low clock enable: powerdown, suspend, self refresh
// - clock enable treated as asynchronous input
// - other inputs sampled on rising edge
// - burst lengths 1, 2, 4, 8, full page
// - read data after cas latency 2 or 3
// - auto refresh and self refresh supported
// - two banks, each with own open row
// - new column address accepted every cycle
// - burst writes or single-location writes
// - 131072 sixteen-bit words per bank
// - byte masks gate read drive and writes
// - chip select high ignores commands
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module sdc_sdram_core (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    input  wire logic                        cke,
    input  wire logic                        cs_n,
    input  wire logic                        ras_n,
    input  wire logic                        cas_n,
    input  wire logic                        we_n,
    input  wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input  wire logic                        low_byte_mask,
    input  wire logic                        high_byte_mask,
    input  wire logic [sdc_pkg::DQ_W-1:0]   dq_in,
    output logic      [sdc_pkg::DQ_W-1:0]   dq_out,
    output logic      [1:0]                  dq_oe,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr
);
    import sdc_pkg::*;

    // every flip-flop except the array
    typedef struct packed {
        logic                        cke_s1;   // first sync stage
        logic                        cke_s2;   // usable clock enable
        sdc_pwr_t                    pwr;      // clock enable state
        logic                        last_ref; // last command was refresh
        logic [ADDR_W-1:0]           mode;     // mode_operation_code
        logic [1:0]                  open;     // bank has a row open
        logic [1:0][ROW_W-1:0]       row;      // open row per bank
        logic                        bact;     // burst running
        logic                        bwr;      // burst is a write
        logic                        bauto;    // close bank at burst end
        logic                        bbank;    // burst bank
        logic [COL_W-1:0]            bcol;     // burst start column
        logic [8:0]                  bidx;     // next beat number
        logic [1:0]                  pv;       // read pipe valid
        logic [1:0][DQ_W-1:0]        pd;       // read pipe data
        logic [DQ_W-1:0]             dq_out;
        logic [1:0]                  dq_oe;
        logic [15:0]                 sref_per; // self refresh interval
        logic [15:0]                 sref_cnt;
        logic [15:0]                 ref_cnt;  // refreshes done
        logic                        pready;
        logic [31:0]                 prdata;
        logic                        pslverr;
    } sdc_st_t;

    sdc_st_t          s;       // registered state
    sdc_st_t          n;       // next state
    logic [2:0]       cmd;     // decoded command
    logic             bgo;     // a beat moves this cycle
    logic             bwr;     // that beat writes
    logic             bbk;     // that beat's bank
    logic [COL_W-1:0] bcl;     // that beat's column
    logic [8:0]       nxt;     // beat number after this one
    logic [8:0]       len;     // beats in the running burst
    logic             rv;      // read word due at the pins
    logic [DQ_W-1:0]  rd;      // that word
    logic             wr_go;   // array write strobe
    logic [IDX_W-1:0] idx;     // array index of the beat

    // the array itself; too big for the state struct
    logic [DQ_W-1:0] mem [0:(2**IDX_W)-1];

    // beats in a burst; single-write mode cuts writes to one
    function automatic logic [8:0] sdc_len(input logic [ADDR_W-1:0] md,
                                           input logic wr);
        logic [8:0] l;
        unique case (md[MR_BL_LSB +: 3])
            BL_2:    l = 9'h002;
            BL_4:    l = 9'h004;
            BL_8:    l = 9'h008;
            BL_FP:   l = BEATS_FP;
            default: l = 9'h001;
        endcase
        if (wr && md[MR_WB_BIT]) begin
            l = 9'h001;
        end
        return l;
    endfunction

    // column of beat i; wraps inside the burst-sized block
    function automatic logic [COL_W-1:0] sdc_col(input logic [COL_W-1:0] st,
                                                 input logic [8:0] i,
                                                 input logic [ADDR_W-1:0] md,
                                                 input logic wr);
        logic [8:0]       l;
        logic [COL_W-1:0] m;
        l = sdc_len(md, wr);
        m = 8'(l - 9'h001);
        if (md[MR_BT_BIT]) begin
            return (st & ~m) | ((st ^ i[COL_W-1:0]) & m);
        end
        return (st & ~m) | ((st + i[COL_W-1:0]) & m);
    endfunction

    // next-state logic for pins, banks, bursts and the apb slave
    always_comb begin
        n = s;
        // cke passes two flops before anything uses it
        n.cke_s1 = cke;
        n.cke_s2 = s.cke_s1;
        // chip select high turns any pattern into no-op
        cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
        bgo = 1'b0;
        bwr = s.bwr;
        bbk = s.bbank;
        bcl = sdc_col(s.bcol, s.bidx, s.mode, s.bwr);
        nxt = s.bidx + 9'h001;
        len = sdc_len(s.mode, s.bwr);
        // cas latency picks the pipe stage feeding the pins
        rv = (s.mode[MR_CL_LSB +: 3] == CL_3) ? s.pv[1] : s.pv[0];
        rd = (s.mode[MR_CL_LSB +: 3] == CL_3) ? s.pd[1] : s.pd[0];

        // apb: one wait state, answer registered
        n.pready  = psel & penable & ~s.pready;
        n.pslverr = 1'b0;
        if (n.pready) begin
            unique case (paddr)
                REG_STATUS: n.prdata = {27'h0, s.bact, s.pwr, s.open};
                REG_MODE:   n.prdata = {22'h0, s.mode};
                REG_SREF:   n.prdata = {16'h0, s.sref_per};
                REG_REFCNT: n.prdata = {16'h0, s.ref_cnt};
                default: begin
                    n.prdata  = 32'h0;
                    n.pslverr = 1'b1; // unmapped address
                end
            endcase
        end
        // write lands on the edge where pready is seen high
        if (psel && penable && s.pready && pwrite && paddr == REG_SREF) begin
            n.sref_per = pwdata[15:0];
        end

        if (!s.cke_s2) begin
            // edge ignored: banks, burst and pipe hold still
            if (s.bact) begin
                n.pwr = SDC_SUSPEND;
            end else if (s.last_ref) begin
                n.pwr = SDC_SELFREF;
            end else begin
                n.pwr = SDC_PDOWN;
            end
            // only a suspended burst keeps driving the bus
            if (n.pwr != SDC_SUSPEND) begin
                n.dq_oe = 2'b00;
            end
            // self refresh paces its own row refreshes
            if (s.pwr == SDC_SELFREF) begin
                if (s.sref_cnt + 16'h0001 >= s.sref_per) begin
                    n.sref_cnt = 16'h0;
                    n.ref_cnt  = s.ref_cnt + 16'h0001;
                end else begin
                    n.sref_cnt = s.sref_cnt + 16'h0001;
                end
            end
        end else begin
            n.pwr = SDC_ACTIVE;
            // leaving self refresh must not re-enter it
            if (s.pwr == SDC_SELFREF) begin
                n.last_ref = 1'b0;
                n.sref_cnt = 16'h0;
            end
            // read pipe shifts; masks gate the drive per byte
            n.pv[0] = 1'b0;
            n.pv[1] = s.pv[0];
            n.pd[1] = s.pd[0];
            n.dq_oe = rv ? ~{high_byte_mask, low_byte_mask} : 2'b00;
            if (rv) begin
                n.dq_out = rd;
            end

            // running burst advances one beat
            if (s.bact) begin
                bgo    = 1'b1;
                n.bidx = nxt;
                // full page keeps going until stopped
                if (nxt == len && len != BEATS_FP) begin
                    n.bact = 1'b0;
                    if (s.bauto) begin
                        n.open[s.bbank] = 1'b0;
                    end
                end
            end

            // a new read or write overrides the running burst; burst stop ends it
            if (cmd != CMD_NOP) begin
                n.last_ref = (cmd == CMD_REF);
            end
            unique case (cmd)
                CMD_ACT: begin
                    n.open[addr[BANK_BIT]] = 1'b1;
                    n.row[addr[BANK_BIT]]  = addr[ROW_W-1:0];
                end
                CMD_RD, CMD_WR: begin
                    // access to a closed bank is dropped
                    if (s.open[addr[BANK_BIT]]) begin
                        bgo     = 1'b1;
                        bwr     = (cmd == CMD_WR);
                        bbk     = addr[BANK_BIT];
                        bcl     = addr[COL_W-1:0];
                        len     = sdc_len(s.mode, bwr);
                        n.bwr   = bwr;
                        n.bbank = bbk;
                        n.bcol  = addr[COL_W-1:0];
                        n.bidx  = 9'h001;
                        n.bauto = addr[PRE_BIT];
                        n.bact  = (len != 9'h001);
                        n.open[bbk] = ~(addr[PRE_BIT] && len == 9'h001);
                    end
                end
                CMD_PRE: begin
                    if (addr[PRE_BIT]) begin
                        n.open = 2'b00;
                    end else begin
                        n.open[addr[BANK_BIT]] = 1'b0;
                    end
                end
                CMD_REF: begin
                    n.ref_cnt = s.ref_cnt + 16'h0001;
                end
                CMD_MRS: begin
                    n.mode = addr;
                end
                CMD_BST: begin
                    n.bact = 1'b0;
                end
                default: begin
                end
            endcase

            // a precharged bank cannot keep bursting
            if (n.bact && !n.open[n.bbank]) begin
                n.bact = 1'b0;
            end
            // read beat enters the latency pipe
            if (bgo && !bwr) begin
                n.pv[0] = 1'b1;
                n.pd[0] = mem[{bbk, s.row[bbk], bcl}];
            end
        end
        wr_go = s.cke_s2 & bgo & bwr;
        idx   = {bbk, s.row[bbk], bcl};
    end

    // array write, byte lanes masked; no reset on storage
    always_ff @(posedge mclk) begin
        if (wr_go) begin
            for (int b = 0; b < 2; b++) begin
                if (!(b == 0 ? low_byte_mask : high_byte_mask)) begin
                    mem[idx][8*b +: 8] <= dq_in[8*b +: 8];
                end
            end
        end
    end

    // state register; pins are taken on the rising edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s          <= '0;
            s.mode     <= MODE_RST;
            s.sref_per <= SREF_RST;
        end else begin
            s <= n;
        end
    end

    // outputs straight from the state flops
    assign dq_out  = s.dq_out;
    assign dq_oe   = s.dq_oe;
    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
endmodule

//--- verilog/sdc_pkg.sv
// constants for the synchronous dram command and address core
// assumes one clock, mclk, at the rate given by CLK_MHZ
package sdc_pkg;
    // array geometry
    localparam int ROW_W    = 9;    // row address bits
    localparam int COL_W    = 8;    // column address bits
    localparam int DQ_W     = 16;   // data word width
    localparam int ADDR_W   = 10;   // address pins incl. bank bit
    localparam int BANK_BIT = 9;    // bank_select_bit position
    localparam int PRE_BIT  = 8;    // precharge_mode_bit position
    localparam int IDX_W    = 1 + ROW_W + COL_W;

    // command codes {row strobe, column strobe, write enable}, low active
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // mode_operation_code fields
    localparam int MR_BL_LSB = 0;   // burst length code, 3 bits
    localparam int MR_BT_BIT = 3;   // 1 = interleaved order
    localparam int MR_CL_LSB = 4;   // cas latency code, 3 bits
    localparam int MR_WB_BIT = 9;   // 1 = single-location writes
    localparam logic [2:0] BL_1  = 3'h0;
    localparam logic [2:0] BL_2  = 3'h1;
    localparam logic [2:0] BL_4  = 3'h2;
    localparam logic [2:0] BL_8  = 3'h3;
    localparam logic [2:0] BL_FP = 3'h7;
    localparam logic [2:0] CL_3  = 3'h3;
    localparam logic [8:0] BEATS_FP = 9'h100;
    localparam logic [9:0] MODE_RST = 10'h020;

    // self refresh spacing: 1K rows every 16 ms
    localparam int CLK_MHZ      = 100;
    localparam int REF_WIN_MS   = 16;
    localparam int REF_ROWS     = 1024;
    localparam int SREF_CYC     = (REF_WIN_MS * 1000 * CLK_MHZ) / REF_ROWS;
    localparam logic [15:0] SREF_RST = 16'(SREF_CYC);

    // apb register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MODE   = 8'h04;
    localparam logic [7:0] REG_SREF   = 8'h08;
    localparam logic [7:0] REG_REFCNT = 8'h0C;

    // clock enable states
    typedef enum logic [1:0] {
        SDC_ACTIVE,
        SDC_PDOWN,
        SDC_SUSPEND,
        SDC_SELFREF
    } sdc_pwr_t;
endpackage

//--- dv/sdc_core_props.sv
// checker for the dram core: byte-mask drive, read latency, cke freeze, apb handshake
// assumes it is bound to sdc_sdram_core and sees its ports only
`timescale 1ns/1ps
module sdc_core_props (
    input wire logic                      mclk,
    input wire logic                      nrst,
    input wire logic                      cke,
    input wire logic                      cs_n,
    input wire logic                      ras_n,
    input wire logic                      cas_n,
    input wire logic                      we_n,
    input wire logic                      low_byte_mask,
    input wire logic                      high_byte_mask,
    input wire logic [sdc_pkg::DQ_W-1:0] dq_out,
    input wire logic [1:0]                dq_oe,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr
);
    import sdc_pkg::*;
    logic rd_cmd; // read command seen on the pins
    assign rd_cmd = !cs_n && ({ras_n, cas_n, we_n} == CMD_RD);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // a masked byte is never driven in the cycle its mask was sampled
    property p_oe_lo; dq_oe[0] |-> !$past(low_byte_mask); endproperty
    property p_oe_hi; dq_oe[1] |-> !$past(high_byte_mask); endproperty
    // output drive starts only two or three edges after a read
    property p_rd_lat; $rose(|dq_oe) |-> $past(rd_cmd, 2) || $past(rd_cmd, 3); endproperty
    // cke passes two flops, so a low cke freezes the edge two ticks on, checked one tick later
    property p_freeze; !$past(cke, 3) |-> $stable(dq_out); endproperty
    property p_wait; psel && penable && !pready |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_idle; !psel |=> !pready; endproperty
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_oe_lo: assert property (p_oe_lo) else $error("low byte driven while masked");
    a_oe_hi: assert property (p_oe_hi) else $error("high byte driven while masked");
    a_rd_lat: assert property (p_rd_lat) else $error("read data at wrong latency");
    a_freeze: assert property (p_freeze) else $error("data moved on a disabled edge");
    a_wait: assert property (p_wait) else $error("apb answer not one wait state");
    a_one: assert property (p_one) else $error("pready longer than one cycle");
    a_idle: assert property (p_idle) else $error("pready without a transfer");
    a_err: assert property (p_err) else $error("error answer with data");
    c_rd: cover property ($rose(|dq_oe));
    c_err: cover property (pslverr);
    c_frz: cover property (!$past(cke, 3) && |dq_oe);
endmodule
bind sdc_sdram_core sdc_core_props i_props (.mclk, .nrst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .low_byte_mask, .high_byte_mask, .dq_out, .dq_oe, .psel, .penable, .prdata, .pready, .pslverr);

//--- dv/sdc_ctl_model.sv
// controller-side model: drives command, address, write data and byte masks
// assumes the bench calls one task per mclk edge from a single process
`timescale 1ns/1ps
module sdc_ctl_model (
    input  wire logic                        mclk,
    output logic                             cs_n,
    output logic                             ras_n,
    output logic                             cas_n,
    output logic                             we_n,
    output logic [sdc_pkg::ADDR_W-1:0]       addr,
    output logic [sdc_pkg::DQ_W-1:0]         dq_in,
    output logic                             low_byte_mask,
    output logic                             high_byte_mask
);
    import sdc_pkg::*;
    // deselected and idle until the first command
    initial begin
        {cs_n, ras_n, cas_n, we_n, addr, dq_in, low_byte_mask, high_byte_mask} = '1;
    end
    // pins change just after an edge and hold until the next one samples them
    task automatic cmd(input logic [2:0] c, input logic [9:0] a, input logic [15:0] d,
                       input logic [1:0] m, input logic sel);
        @(posedge mclk);
        {cs_n, ras_n, cas_n, we_n} <= {~sel, c};
        {addr, dq_in, high_byte_mask, low_byte_mask} <= {a, d, m};
    endtask
    // release: address and data flip so stale values never pass for valid ones
    task automatic idle();
        cmd(CMD_NOP, ~addr, ~dq_in, 2'h0, 1'b0);
    endtask
endmodule

//--- dv/tb.sv
// bench: random bursts in every order, masks, precharge, power states, apb
// assumes the controller model on the dram pins and an apb master here
`timescale 1ns/1ps
module tb;
    import sdc_pkg::*;
    logic        mclk, nrst, cke, cs_n, ras_n, cas_n, we_n, e, bk, bt;
    logic        low_byte_mask, high_byte_mask, psel, penable, pwrite, pready, pslverr;
    logic [9:0]  addr;
    logic [15:0] dq_in, dq_out, d;
    logic [1:0]  dq_oe;
    logic [7:0]  paddr, col;
    logic [8:0]  row;
    logic [31:0] pwdata, prdata, r;
    logic [31:0] seed = 32'h72BB; // fixed seed keeps runs repeatable
    logic [15:0] mem [int];       // expected array contents
    int          cl, len, errors, check_count;
    sdc_ctl_model i_ctl (.mclk, .cs_n, .ras_n, .cas_n, .we_n, .addr, .dq_in,
        .low_byte_mask, .high_byte_mask);
    sdc_sdram_core i_dut (.mclk, .nrst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
        .low_byte_mask, .high_byte_mask, .dq_in, .dq_out, .dq_oe, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // column of beat i: the wrap stays inside the burst-sized block
    function automatic logic [7:0] colx(logic [7:0] s, int i, int n, logic il);
        logic [7:0] m;
        m = 8'(n - 1);
        return il ? (s & ~m) | ((s ^ 8'(i)) & m) : (s & ~m) | ((s + 8'(i)) & m);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; the answer is taken at the edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 40);
        // a slave that never answers counts as a mismatch
        if (n >= 40) errors++;
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic rs(input logic [7:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, r, x);
    endtask
    task automatic c(input logic [2:0] k, input logic [9:0] a);
        i_ctl.cmd(k, a, 16'h0, 2'h0, 1'b1);
        i_ctl.idle();
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        test_done();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {nrst, cke} = 2'h1;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        rs(REG_STATUS, 32'h0, "status");
        rs(REG_MODE, 32'(MODE_RST), "mode");
        rs(REG_SREF, 32'(SREF_RST), "sref");
        rs(8'h10, 32'h0, "unmapped");
        chk("slverr", 32'(e), 32'h1);
        apb(1'b1, REG_SREF, 32'h4);
        apb(1'b1, REG_MODE, 32'h3FF);
        rs(REG_SREF, 32'h4, "sref_rw");
        rs(REG_MODE, 32'(MODE_RST), "mode_ro");
        // lengths 1, 2, 4 and 8 (no full page), both orders and both latencies: write a burst, read it straight back
        for (int k = 0; k < 16; k++) begin
            bt = k[2];
            cl = k[3] ? 3 : 2;
            len = 1 << k[1:0];
            {bk, row, col} = 18'(rnd());
            c(CMD_MRS, {3'h0, 3'(cl), bt, 1'b0, k[1:0]});
            c(CMD_ACT, {bk, row});
            for (int i = 0; i < len; i++) begin
                d = 16'(rnd());
                mem[int'({bk, row, colx(col, i, len, bt)})] = d;
                if (i == 0) i_ctl.cmd(CMD_WR, {bk, 1'b0, col}, d, 2'h0, 1'b1);
                else i_ctl.cmd(CMD_NOP, 10'h3FF, d, 2'h0, 1'b0);
            end
            c(CMD_RD, {bk, 1'b0, col});
            repeat (cl - 1) @(posedge mclk);
            for (int i = 0; i < len; i++) begin
                #1 chk("dq_out", 32'(dq_out), 32'(mem[int'({bk, row, colx(col, i, len, bt)})]));
                chk("dq_oe", 32'(dq_oe), 32'h3);
                @(posedge mclk);
            end
            #1 chk("dq_oe_end", 32'(dq_oe), 32'h0);
            c(CMD_PRE, {bk, 9'h0});
        end
        // high byte masked on write, both masked on read
        c(CMD_MRS, MODE_RST);
        c(CMD_ACT, 10'h005);
        i_ctl.cmd(CMD_WR, 10'h003, 16'hA55A, 2'h0, 1'b1);
        i_ctl.cmd(CMD_WR, 10'h003, 16'h3CC3, 2'h2, 1'b1);
        c(CMD_RD, 10'h003);
        @(posedge mclk);
        #1 chk("masked_write", 32'(dq_out), 32'hA5C3);
        i_ctl.cmd(CMD_RD, 10'h003, 16'h0, 2'h3, 1'b1);
        i_ctl.cmd(CMD_NOP, 10'h3FC, 16'h0, 2'h3, 1'b0);
        i_ctl.idle();
        #1 chk("masked_read", 32'(dq_oe), 32'h0);
        // single-location writes: the beat after a write must not land
        c(CMD_MRS, 10'h222);
        i_ctl.cmd(CMD_WR, 10'h011, 16'h1111, 2'h0, 1'b1);
        i_ctl.cmd(CMD_WR, 10'h010, 16'h2222, 2'h0, 1'b1);
        i_ctl.cmd(CMD_NOP, 10'h3FF, 16'h3333, 2'h0, 1'b0);
        c(CMD_RD, 10'h010);
        @(posedge mclk);
        #1 chk("single_wr0", 32'(dq_out), 32'h2222);
        @(posedge mclk);
        #1 chk("single_wr1", 32'(dq_out), 32'h1111);
        // full page runs on until burst stop ends it
        c(CMD_MRS, 10'h027);
        c(CMD_RD, 10'h010);
        c(CMD_BST, 10'h0);
        repeat (2) @(posedge mclk);
        #1 chk("burst_stop", 32'(dq_oe), 32'h0);
        c(CMD_MRS, MODE_RST);
        // bank bookkeeping seen through the open bits of the status word
        c(CMD_ACT, 10'h200);
        rs(REG_STATUS, 32'h3, "both_open");
        c(CMD_PRE, 10'h200);
        rs(REG_STATUS, 32'h1, "pre_one");
        i_ctl.cmd(CMD_ACT, 10'h200, 16'h0, 2'h0, 1'b0);
        i_ctl.idle();
        rs(REG_STATUS, 32'h1, "deselected");
        c(CMD_ACT, 10'h200);
        c(CMD_PRE, 10'h100);
        rs(REG_STATUS, 32'h0, "pre_all");
        c(CMD_ACT, 10'h005);
        c(CMD_RD, 10'h103);
        repeat (3) @(posedge mclk);
        rs(REG_STATUS, 32'h0, "auto_pre");
        // power-down, then self refresh after a refresh command
        cke <= 1'b0;
        repeat (5) @(posedge mclk);
        rs(REG_STATUS, 32'h4, "pdown");
        cke <= 1'b1;
        repeat (4) @(posedge mclk);
        c(CMD_REF, 10'h0);
        cke <= 1'b0;
        repeat (40) @(posedge mclk);
        rs(REG_STATUS, 32'hC, "selfref");
        apb(1'b0, REG_REFCNT, 32'h0);
        chk("refcnt", 32'(r > 32'h2), 32'h1);
        cke <= 1'b1;
        repeat (4) @(posedge mclk);
        rs(REG_STATUS, 32'h0, "awake");
        // clock suspend in the middle of an eight-beat read
        c(CMD_MRS, 10'h023);
        c(CMD_ACT, 10'h005);
        c(CMD_RD, 10'h000);
        repeat (2) @(posedge mclk);
        cke <= 1'b0;
        repeat (6) @(posedge mclk);
        rs(REG_STATUS, 32'h19, "suspend");
        cke <= 1'b1;
        repeat (12) @(posedge mclk);
        test_done();
    end
endmodule
